// file: hdl/opx_crossbar.sv
// output pin crossbar: routes internal functions and gpio onto shared pins
// Operation
// [RULE1] pin A: cal, quad, comm, gpio0
// [RULE2] complement A tristated in calibration mode
// [RULE3] complement A inverts A under RS422
// [RULE4] complement A: comm U or gpio1
// [RULE5] pin B: cal, quad, comm, gpio2
// [RULE6] complement B: tristate, diff, comm, gpio3
// [RULE7] pin Z: pwm, index, comm, clock, gpio4
// [RULE8] complement Z: diff, comm, clock, gpio5
// [RULE9] inverted serial out: diff or clock
// [RULE10] i2c pins carry sine calibration in test
// [RULE11] index pins: comparator, sub-interface, gpio
// [RULE12] serial out follows protocol, format only
// [RULE13] format bits 4-7: single-ended or RS422
// [RULE14] receiver fields: cmos, ttl, rs422, off
// [RULE15] driven gpio follows force bit
// [RULE16] readback returns pin levels
// [RULE17] analog drivers enabled by enable bit
// [RULE18] direction bit enables gpio driver
// [RULE19] gpio is fallback on unclaimed pins
// [RULE20] undefined complement cases tristate
`timescale 1ns/1ps
module opx_crossbar (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire opx_pkg::opx_func_type func,
    output opx_pkg::opx_pin_type pin_a,
    output opx_pkg::opx_pin_type pin_a_complement,
    output opx_pkg::opx_pin_type pin_b,
    output opx_pkg::opx_pin_type pin_b_complement,
    output opx_pkg::opx_pin_type pin_z,
    output opx_pkg::opx_pin_type index_pin_complement,
    output opx_pkg::opx_pin_type pin_serial_out,
    output opx_pkg::opx_pin_type pin_serial_out_n,
    output opx_pkg::opx_pin_type pin_sda,
    output opx_pkg::opx_pin_type pin_scl,
    output opx_pkg::opx_pin_type pin_index_pos,
    output opx_pkg::opx_pin_type pin_index_neg,
    input wire logic [7:0] pin_level_in,
    output logic index_input_pos,
    output logic index_input_neg,
    output logic sub_interface_data,
    output logic serial_out_rs422,
    output opx_pkg::opx_rx_fmt_type clock_in_receiver_format,
    output opx_pkg::opx_rx_fmt_type serial_in_receiver_format,
    output logic analog_line_driver_enable
);
    logic [7:0] format_reg;
    logic adrv_reg;
    logic [7:0] dir_reg;
    logic [7:0] force_reg;
    logic [6:0] sel_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] level_sync;
    logic wr_en;
    logic [9:0] wr_addr;
    logic rd_en;
    logic [9:0] rd_addr;

    opx_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .rd_en(rd_en),
        .rd_addr(rd_addr)
    );

    // pin levels come from outside the clock domain
    opx_sync3 #(.WIDTH(opx_pkg::OPX_GPIO_N)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .async_in(pin_level_in),
        .sync_out(level_sync)
    );

    wire wr_format = wr_en & (wr_addr == opx_pkg::OPX_ADDR_FORMAT);
    wire wr_adrv = wr_en & (wr_addr == opx_pkg::OPX_ADDR_ADRV);
    wire wr_dir = wr_en & (wr_addr == opx_pkg::OPX_ADDR_DIR);
    wire wr_force = wr_en & (wr_addr == opx_pkg::OPX_ADDR_FORCE);
    wire wr_sel = wr_en & (wr_addr == opx_pkg::OPX_ADDR_SEL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            format_reg <= opx_pkg::OPX_FORMAT_RESET;
            adrv_reg <= 1'b0;
            dir_reg <= 8'h00;
            force_reg <= 8'h00;
            sel_reg <= opx_pkg::OPX_SEL_RESET;
        end else if (ce) begin
            if (wr_format) format_reg <= hwdata[7:0];
            if (wr_adrv) adrv_reg <= hwdata[0];
            if (wr_dir) dir_reg <= hwdata[7:0];
            if (wr_force) force_reg <= hwdata[7:0];
            if (wr_sel) sel_reg <= hwdata[6:0];
        end
    end

    // [RULE16] readback of levels
    always_comb begin
        rdata_next = 8'h00;
        unique case (rd_addr)
            opx_pkg::OPX_ADDR_FORMAT: rdata_next = format_reg;
            opx_pkg::OPX_ADDR_ADRV: rdata_next = {7'h00, adrv_reg};
            opx_pkg::OPX_ADDR_DIR: rdata_next = dir_reg;
            opx_pkg::OPX_ADDR_READBACK: rdata_next = level_sync;
            opx_pkg::OPX_ADDR_SEL: rdata_next = {1'b0, sel_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 8'h00;
        end else if (ce && rd_en) begin
            rdata_reg <= rdata_next;
        end
    end
    assign hrdata = {24'h000000, rdata_reg};

    opx_pkg::opx_sel_type sel;
    assign sel = opx_pkg::opx_sel_type'(sel_reg);
    wire tma = sel.tma;
    wire quad = sel.quad_en;
    wire comm = sel.comm_en;
    wire clkrep = sel.clkrep_en;
    // [RULE13] output format bits
    wire fmt_slo = format_reg[opx_pkg::OPX_F_SLO];
    wire fmt_a = format_reg[opx_pkg::OPX_F_A];
    wire fmt_b = format_reg[opx_pkg::OPX_F_B];
    wire fmt_z = format_reg[opx_pkg::OPX_F_Z];

    // [RULE14] receiver format fields
    assign clock_in_receiver_format = opx_pkg::opx_rx_fmt_type'(format_reg[opx_pkg::OPX_F_CLKIN_LO +: 2]);
    assign serial_in_receiver_format = opx_pkg::opx_rx_fmt_type'(format_reg[opx_pkg::OPX_F_SERIN_LO +: 2]);
    assign serial_out_rs422 = fmt_slo;
    // [RULE17] analog driver enable
    assign analog_line_driver_enable = adrv_reg;

    // [RULE15] gpio drive level
    function automatic opx_pkg::opx_pin_type gpio_pin(input logic dir, input logic fval);
        opx_pkg::opx_pin_type p;
        p.o = fval;
        // [RULE18] direction enables driver
        p.oe_n = ~dir;
        return p;
    endfunction

    function automatic opx_pkg::opx_pin_type drive(input logic v);
        opx_pkg::opx_pin_type p;
        p.o = v;
        p.oe_n = 1'b0;
        return p;
    endfunction

    localparam opx_pkg::opx_pin_type PIN_OFF = '{o: 1'b0, oe_n: 1'b1};

    // [RULE19] gpio fallback per pin
    opx_pkg::opx_pin_type gp [8];
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gp
            assign gp[gi] = gpio_pin(dir_reg[gi], force_reg[gi]);
        end
    endgenerate

    // [RULE1] pin A select
    wire a_val = quad ? func.quad_a : func.comm_u;
    assign pin_a = tma ? drive(func.cosine_pos_observe) : ((quad | comm) ? drive(a_val) : gp[0]);

    // [RULE2] [RULE3] [RULE4] complement of A
    assign pin_a_complement = tma ? PIN_OFF : fmt_a ? drive(~pin_a.o) :
                              (quad & comm) ? drive(func.comm_u) : gp[1];

    // [RULE5] pin B select
    wire b_val = quad ? func.quad_b : func.comm_v;
    assign pin_b = tma ? drive(func.cosine_neg_observe) : ((quad | comm) ? drive(b_val) : gp[2]);

    // [RULE6] complement of B
    assign pin_b_complement = tma ? PIN_OFF : fmt_b ? drive(~pin_b.o) :
                              (quad & comm) ? drive(func.comm_v) : gp[3];

    // [RULE7] pin Z priority
    assign pin_z = sel.pwm_en ? drive(func.pwm) : quad ? drive(func.quad_z) : comm ? drive(func.comm_w) :
                   clkrep ? drive(func.master_clock_output) : gp[4];

    // [RULE8] [RULE20] complement of Z
    wire nz_clk = (quad ^ comm) & clkrep & fmt_slo;
    assign index_pin_complement = fmt_z ? drive(~pin_z.o) : (quad & comm) ? drive(func.comm_w) :
                                  nz_clk ? drive(func.master_clock_output) : (~quad & ~comm) ? gp[5] : PIN_OFF;

    // [RULE12] serial out follows the protocol
    assign pin_serial_out = drive(func.serial_out);
    // [RULE9] [RULE20] inverted serial out
    assign pin_serial_out_n = fmt_slo ? drive(~func.serial_out) :
                              clkrep ? drive(func.master_clock_output) : PIN_OFF;

    // [RULE10] i2c pins
    assign pin_sda = tma ? drive(func.sine_pos_observe) : drive(func.i2c_sda);
    assign pin_scl = tma ? drive(func.sine_neg_observe) : drive(func.i2c_scl);

    // [RULE11] index pins: comparator inputs released, clock out, data in
    assign pin_index_pos = sel.idxcmp_en ? PIN_OFF : sel.abs_en ? drive(func.sub_interface_clock) : gp[6];
    assign pin_index_neg = (sel.idxcmp_en | sel.abs_en) ? PIN_OFF : gp[7];
    assign index_input_pos = sel.idxcmp_en & level_sync[6];
    assign index_input_neg = sel.idxcmp_en & level_sync[7];
    assign sub_interface_data = ~sel.idxcmp_en & sel.abs_en & level_sync[7];

    // [RULE2] calibration tristates
    cal_tri_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tma |-> pin_a_complement.oe_n && pin_b_complement.oe_n) else $error("complement not tristated"); // [RULE2]
    // [RULE3] differential pair
    diff_a_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!tma && fmt_a) |-> (pin_a_complement.o != pin_a.o)) else $error("A pair not differential"); // [RULE3]
    // [RULE1] pin A calibration
    pin_a_cal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tma |-> (pin_a.o == func.cosine_pos_observe) && !pin_a.oe_n) else $error("pin A not calibration"); // [RULE1]
    // [RULE7] pwm priority
    pwm_z_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sel.pwm_en |-> (pin_z.o == func.pwm)) else $error("pin Z not pwm"); // [RULE7]
    // [RULE9] inverted serial out
    nslo_diff_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fmt_slo |-> (pin_serial_out_n.o != pin_serial_out.o)) else $error("serial pair wrong"); // [RULE9]
    // [RULE10] i2c calibration
    sda_cal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tma |-> (pin_sda.o == func.sine_pos_observe)) else $error("sda not calibration"); // [RULE10]
    // [RULE18] direction write
    dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && wr_dir) |=> (gp[0].oe_n == ~$past(hwdata[0]))) else $error("direction not applied"); // [RULE18]
    // [RULE17] analog enable
    adrv_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && wr_adrv) |=> (analog_line_driver_enable == $past(hwdata[0]))) else $error("adrv not applied"); // [RULE17]
    // [RULE20] undefined complement Z
    nz_tri_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!fmt_z && (quad ^ comm) && !nz_clk) |-> index_pin_complement.oe_n) else $error("NZ not tristated"); // [RULE20]
endmodule // opx_crossbar

// file: hdl/opx_pkg.sv
// package for the output pin crossbar: register map, fields, reset values
package opx_pkg;

    // byte addresses (some printed offsets are not multiples of four: index times four)
    localparam logic [7:0] OPX_IDX_FORMAT = 8'h00;
    localparam logic [7:0] OPX_IDX_ADRV = 8'h02;
    localparam logic [7:0] OPX_IDX_READBACK = 8'h75;
    localparam logic [7:0] OPX_IDX_DIR = 8'h74;
    localparam logic [7:0] OPX_IDX_SEL = 8'h10;
    localparam logic [9:0] OPX_ADDR_FORMAT = {OPX_IDX_FORMAT, 2'b00};
    localparam logic [9:0] OPX_ADDR_ADRV = {OPX_IDX_ADRV, 2'b00};
    localparam logic [9:0] OPX_ADDR_READBACK = {OPX_IDX_READBACK, 2'b00};
    localparam logic [9:0] OPX_ADDR_DIR = {OPX_IDX_DIR, 2'b00};
    localparam logic [9:0] OPX_ADDR_SEL = {OPX_IDX_SEL, 2'b00};
    // force values share the readback word: writes go to force, reads return levels
    localparam logic [9:0] OPX_ADDR_FORCE = OPX_ADDR_READBACK;

    // pin_format_config fields
    localparam int OPX_F_CLKIN_LO = 0;
    localparam int OPX_F_SERIN_LO = 2;
    localparam int OPX_F_SLO = 4;
    localparam int OPX_F_A = 5;
    localparam int OPX_F_B = 6;
    localparam int OPX_F_Z = 7;
    localparam logic [7:0] OPX_FORMAT_RESET = 8'h10;

    // selection register fields
    localparam int OPX_S_TMA = 0;
    localparam int OPX_S_QUAD = 1;
    localparam int OPX_S_COMM = 2;
    localparam int OPX_S_CLKREP = 3;
    localparam int OPX_S_PWM = 4;
    localparam int OPX_S_IDXCMP = 5;
    localparam int OPX_S_ABS = 6;
    localparam logic [6:0] OPX_SEL_RESET = 7'h00;

    localparam int OPX_GPIO_N = 8;

    typedef enum logic [1:0] {
        OPX_RX_CMOS = 2'h0,
        OPX_RX_TTL = 2'h1,
        OPX_RX_RS422 = 2'h2,
        OPX_RX_OFF = 2'h3
    } opx_rx_fmt_type;

    // selection bits bundled for the crossbar
    typedef struct packed {
        logic abs_en;
        logic idxcmp_en;
        logic pwm_en;
        logic clkrep_en;
        logic comm_en;
        logic quad_en;
        logic tma;
    } opx_sel_type;

    // one driven pin: level and active-low enable
    typedef struct packed {
        logic o;
        logic oe_n;
    } opx_pin_type;

    // internal function signals offered to the crossbar
    typedef struct packed {
        logic quad_a;
        logic quad_b;
        logic quad_z;
        logic comm_u;
        logic comm_v;
        logic comm_w;
        logic pwm;
        logic master_clock_output;
        logic serial_out;
        logic i2c_sda;
        logic i2c_scl;
        logic sub_interface_clock;
        logic cosine_pos_observe;
        logic cosine_neg_observe;
        logic sine_pos_observe;
        logic sine_neg_observe;
    } opx_func_type;

endpackage

// file: hdl/opx_sync3.sv
// three-stage synchroniser bank with agreement filter for pin inputs
`timescale 1ns/1ps
module opx_sync3 #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
    wire [WIDTH-1:0] out_next = (agree & s3_reg) | (~agree & out_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else if (ce) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule // opx_sync3

// file: hdl/opx_ahb_slave.sv
// ahb-lite slave front end: captures the address phase, answers with zero wait
`timescale 1ns/1ps
module opx_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic wr_en,
    output logic [9:0] wr_addr,
    output logic rd_en,
    output logic [9:0] rd_addr
);
    localparam logic [2:0] SIZE_WORD = 3'h2;
    logic wr_pend_reg;
    logic [9:0] addr_reg;
    // only whole-word transfers are acted on; others complete with no effect
    wire take = hsel & hready & htrans[1] & (hsize == SIZE_WORD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 10'h000;
        end else if (ce) begin
            wr_pend_reg <= take & hwrite;
            if (take) begin
                addr_reg <= haddr[9:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = wr_pend_reg & ce;
    assign wr_addr = addr_reg;
    assign rd_en = take & ~hwrite;
    assign rd_addr = haddr[9:0];
endmodule // opx_ahb_slave

// file: tb/opx_line_model.sv
// far-side line model: resolves the eight gpio-capable pin wires
`timescale 1ns/1ps
module opx_line_model (
    input wire opx_pkg::opx_pin_type [7:0] pins,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] level
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // an undriven line is pulled up by the receiver termination
            level[i] = !pins[i].oe_n ? pins[i].o : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule // opx_line_model

// file: tb/tb_top.sv
// self-checking bench for the output pin crossbar
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hreadyout, hresp, ip, in, sd, so422, adrv;
    logic [31:0] hrdata, q;
    logic [7:0] ext_en = 8'h0, ext_val = 8'h0, lvl;
    opx_pkg::opx_func_type func = '0;
    opx_pkg::opx_pin_type pa, na, pb, nb, pz, nz, so, nso, sda, scl, zp, zn;
    opx_pkg::opx_rx_fmt_type rx_clk, rx_ser;
    logic [15:0] pat [4] = '{16'h00ff, 16'h0f0f, 16'h3333, 16'h5555};
    int n_fail = 0;
    int n_tests = 0;

    always #2 hclk = ~hclk;

    opx_crossbar dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .func(func), .pin_a(pa), .pin_a_complement(na), .pin_b(pb),
        .pin_b_complement(nb), .pin_z(pz), .index_pin_complement(nz), .pin_serial_out(so),
        .pin_serial_out_n(nso), .pin_sda(sda), .pin_scl(scl), .pin_index_pos(zp), .pin_index_neg(zn),
        .pin_level_in(lvl), .index_input_pos(ip), .index_input_neg(in), .sub_interface_data(sd),
        .serial_out_rs422(so422), .clock_in_receiver_format(rx_clk), .serial_in_receiver_format(rx_ser),
        .analog_line_driver_enable(adrv));

    opx_line_model partner (.pins({zn, zp, nz, pz, nb, pb, na, pa}), .ext_en(ext_en), .ext_val(ext_val),
        .level(lvl));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cpin(input string nm, input opx_pkg::opx_pin_type got, input logic oe, input logic o);
        chk({nm, "_oe_n"}, 32'(got.oe_n), 32'(oe));
        if (!oe) begin
            chk(nm, 32'(got.o), 32'(o));
        end
    endtask

    // called right after a rising edge; zero-wait slave, but no latency assumed
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        haddr <= {22'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        q = hrdata;
        if (k >= 50) begin
            n_fail++;
        end
        chk("hresp", 32'(hresp), 32'h0);
    endtask

    task automatic rd(input string nm, input logic [9:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask

    task automatic check_pins(input opx_pkg::opx_sel_type s, input logic [3:0] fm, input opx_pkg::opx_func_type f);
        logic [7:0] g;
        logic ea, eb, ez, both, zclk, none;
        g = 8'ha5;
        both = s.quad_en & s.comm_en;
        none = !s.quad_en & !s.comm_en;
        zclk = (s.quad_en ^ s.comm_en) & s.clkrep_en & fm[0];
        ea = s.tma ? f.cosine_pos_observe : s.quad_en ? f.quad_a : s.comm_en ? f.comm_u : g[0];
        eb = s.tma ? f.cosine_neg_observe : s.quad_en ? f.quad_b : s.comm_en ? f.comm_v : g[2];
        ez = s.pwm_en ? f.pwm : s.quad_en ? f.quad_z : s.comm_en ? f.comm_w :
            s.clkrep_en ? f.master_clock_output : g[4];
        cpin("pin_a", pa, 1'b0, ea);
        cpin("pin_na", na, s.tma, fm[1] ? ~ea : (both ? f.comm_u : g[1]));
        cpin("pin_b", pb, 1'b0, eb);
        cpin("pin_nb", nb, s.tma, fm[2] ? ~eb : (both ? f.comm_v : g[3]));
        cpin("pin_z", pz, 1'b0, ez);
        cpin("pin_nz", nz, !(fm[3] | both | zclk | none),
            fm[3] ? ~ez : both ? f.comm_w : zclk ? f.master_clock_output : g[5]);
        cpin("pin_nso", nso, !(fm[0] | s.clkrep_en), fm[0] ? ~f.serial_out : f.master_clock_output);
        cpin("pin_so", so, 1'b0, f.serial_out);
        cpin("pin_sda", sda, 1'b0, s.tma ? f.sine_pos_observe : f.i2c_sda);
        cpin("pin_scl", scl, 1'b0, s.tma ? f.sine_neg_observe : f.i2c_scl);
        cpin("pin_zp", zp, s.idxcmp_en, s.abs_en ? f.sub_interface_clock : g[6]);
        cpin("pin_zn", zn, s.idxcmp_en | s.abs_en, g[7]);
        chk("so_rs422", 32'(so422), 32'(fm[0]));
    endtask

    initial begin
        // about three times the expected run length, still far below the cycle budget
        #200000;
        n_fail++;
        stop_test;
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("format_rst", opx_pkg::OPX_ADDR_FORMAT, 32'h10);
        rd("adrv_rst", opx_pkg::OPX_ADDR_ADRV, 32'h0);
        cpin("gpio0_rst", pa, 1'b1, 1'b0);
        xfer(1'b1, opx_pkg::OPX_ADDR_DIR, 32'hff);
        xfer(1'b1, opx_pkg::OPX_ADDR_FORCE, 32'ha5);
        // every selection and output format, four func patterns each
        for (int c = 0; c < 2048; c++) begin
            xfer(1'b1, opx_pkg::OPX_ADDR_SEL, 32'(c[6:0]));
            xfer(1'b1, opx_pkg::OPX_ADDR_FORMAT, {24'h0, c[10:7], 4'h0});
            for (int p = 0; p < 4; p++) begin
                func <= pat[p];
                #1;
                check_pins(c[6:0], c[10:7], pat[p]);
                @(posedge hclk);
            end
        end
        xfer(1'b1, opx_pkg::OPX_ADDR_SEL, 32'h0);
        for (int r = 0; r < 4; r++) begin
            xfer(1'b1, opx_pkg::OPX_ADDR_FORMAT, 32'({r[1:0], r[1:0]}));
            // register lands on the edge that ends xfer: look after it settles
            #1;
            chk("rx_clk", 32'(rx_clk), 32'(r));
            chk("rx_ser", 32'(rx_ser), 32'(r));
        end
        for (int v = 1; v >= 0; v--) begin
            xfer(1'b1, opx_pkg::OPX_ADDR_ADRV, 32'(v));
            #1;
            chk("adrv", 32'(adrv), 32'(v));
            rd("adrv_rd", opx_pkg::OPX_ADDR_ADRV, 32'(v));
        end
        xfer(1'b1, opx_pkg::OPX_ADDR_FORCE, 32'h5a);
        repeat (8) @(posedge hclk);
        rd("readback_out", opx_pkg::OPX_ADDR_READBACK, 32'h5a);
        xfer(1'b1, opx_pkg::OPX_ADDR_DIR, 32'h0);
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        repeat (8) @(posedge hclk);
        cpin("gpio2_in", pb, 1'b1, 1'b0);
        rd("readback_in", opx_pkg::OPX_ADDR_READBACK, 32'h3c);
        ext_val <= 8'h80;
        xfer(1'b1, opx_pkg::OPX_ADDR_SEL, 32'h20);
        repeat (8) @(posedge hclk);
        chk("idx_pos", 32'(ip), 32'h0);
        chk("idx_neg", 32'(in), 32'h1);
        ext_en <= 8'h80;
        xfer(1'b1, opx_pkg::OPX_ADDR_SEL, 32'h40);
        repeat (8) @(posedge hclk);
        chk("sub_data", 32'(sd), 32'h1);
        xfer(1'b1, 10'h300, 32'hff);
        rd("unmapped", 10'h300, 32'h0);
        // reset in mid-run must restore the documented defaults
        xfer(1'b1, opx_pkg::OPX_ADDR_FORMAT, 32'hff);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("format_rst2", opx_pkg::OPX_ADDR_FORMAT, 32'h10);
        chk("so_rs422_rst", 32'(so422), 32'h1);
        stop_test;
    end
endmodule // tb_top
